// ===== dv/head_model.sv
// behavioural head and track detector model outside the seek logic
`timescale 1ns/100ps
`default_nettype none
module head_model (
   input wire logic clock,
   input wire logic reset,
   input wire seek_pkg::drive_out_s drive,
   input wire logic stall,
   output logic pos_n,
   output logic neg_n,
   output logic on_track
);
   import seek_pkg::*;
   logic [3:0] cnt_ff;
   logic alt_ff;
   logic moving;
   assign moving = drive.velocity_mode && (drive.forward || drive.reverse);
   // a crossing every 16 cycles, two cycles low, pos and neg taking turns
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cnt_ff <= 4'h0;
         alt_ff <= 1'h0;
         pos_n <= 1'h1;
         neg_n <= 1'h1;
         on_track <= 1'h0;
      end else begin
         cnt_ff <= moving ? cnt_ff + 4'h1 : 4'h0;
         if (cnt_ff == 4'hf) begin
            alt_ff <= !alt_ff;
         end
         pos_n <= !(moving && cnt_ff[3:1] == 3'h7 && !alt_ff);
         neg_n <= !(moving && cnt_ff[3:1] == 3'h7 && alt_ff);
         // stall keeps the head off track so settling never finishes
         on_track <= !drive.velocity_mode && !stall;
      end
   end
endmodule : head_model
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the head seek and restore logic
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import seek_pkg::*;
   logic clock;
   logic reset;
   logic clk_en;
   apb_req_s req;
   apb_rsp_s rsp;
   servo_in_s servo;
   drive_out_s drive;
   logic index_mark, guardband, seek_ack, homing_pulse, done, illegal, tmo_n, ready;
   logic pos_n, neg_n, on_trk, sync_bit, slot, stall, slv_err;
   logic [31:0] rd;
   int error_cnt = 0;
   int checked = 0;
   int ack_cnt = 0;
   int hp_cnt = 0;
   logic xing_n, xing_d;
   int xing_cnt = 0;
   int xing_base = 0;
   assign servo = {pos_n, neg_n, on_trk, sync_bit, slot};
   head_seek_restore_logic uut (.clock(clock), .reset(reset), .clk_en(clk_en),
      .apb_req(req), .apb_rsp(rsp), .servo(servo), .drive(drive),
      .index_mark(index_mark), .guardband(guardband), .crossing_pulse_n(xing_n),
      .seek_ack(seek_ack), .homing_pulse(homing_pulse), .positioning_done(done),
      .illegal_address(illegal), .positioning_timeout_n(tmo_n), .ready(ready));
   head_model far_end (.clock(clock), .reset(reset), .drive(drive), .stall(stall),
      .pos_n(pos_n), .neg_n(neg_n), .on_track(on_trk));
   initial begin
      clock = 1'h0;
      forever #10 clock = ~clock;
   end
   always @(posedge clock) begin
      if (seek_ack === 1'h1) ack_cnt <= ack_cnt + 1;
      if (homing_pulse === 1'h1) hp_cnt <= hp_cnt + 1;
      xing_d <= xing_n;
      if (xing_d === 1'h1 && xing_n === 1'h0) xing_cnt <= xing_cnt + 1;
   end
   task automatic chk1(input logic got, input logic exp, input string what);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t %s: got %b want %b", $time, what, got, exp);
      end
   endtask : chk1
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t %s: got %h want %h", $time, what, got, exp);
      end
   endtask : chk32
   // request held until the edge that samples pready high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      req <= {1'h1, 1'h0, wr, a, d};
      @(posedge clock);
      req.penable <= 1'h1;
      do @(posedge clock); while (rsp.pready !== 1'h1);
      rd = rsp.prdata;
      slv_err = rsp.pslverr;
      req <= '0;
   endtask : apb
   task automatic seek(input logic [9:0] t);
      apb(1'h1, TARGET_OFS, {22'h0, t});
      apb(1'h1, CTRL_OFS, 32'h1);
      repeat (2) @(posedge clock);
   endtask : seek
   task automatic wait_done(input int n);
      for (int i = 0; i < n && done !== 1'h1; i++) @(posedge clock);
      chk1(done, 1'h1, "seek finished");
   endtask : wait_done
   // sync bit set one edge ahead of the slot pulse that samples it
   task automatic shift_in(input logic [4:0] bits, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge clock);
         sync_bit <= bits[i];
         @(posedge clock);
         slot <= 1'h1;
         repeat (4) @(posedge clock);
         slot <= 1'h0;
         repeat (4) @(posedge clock);
      end
   endtask : shift_in
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (60000) @(posedge clock);
      error_cnt++;
      $display("BAD t=%0t watchdog expired", $time);
      test_done();
   end
   initial begin
      req = '0;
      clk_en = 1'h1;
      reset = 1'h1;
      sync_bit = 1'h0;
      slot = 1'h0;
      stall = 1'h0;
      repeat (12) @(posedge clock);
      reset <= 1'h0;
      apb(1'h0, LIMIT_OFS, 32'h0);
      chk32(rd, 32'h31f, "limit reset value");
      apb(1'h1, STATUS_OFS, 32'hf);
      apb(1'h0, STATUS_OFS, 32'h0);
      chk32(rd & 32'hf, 32'h0, "status read only");
      chk1(tmo_n, 1'h1, "no timeout at reset");
      apb(1'h0, 12'h018, 32'h0);
      chk1(slv_err, 1'h1, "unmapped error");
      chk32(rd, 32'h0, "unmapped data");
      $display("test registers done");
      seek(10'h005);
      chk32(ack_cnt, 32'h0, "seek while not done");
      seek(10'h320);
      chk1(illegal, 1'h1, "out of range flagged");
      chk32(ack_cnt, 32'h0, "out of range refused");
      $display("test strobe gating done");
      shift_in(5'h0a, 5);
      chk1(guardband, 1'h1, "guard pattern a");
      shift_in(5'h15, 5);
      chk1(guardband, 1'h1, "guard pattern b");
      shift_in(5'h1f, 5);
      chk1(guardband, 1'h0, "out of guardband");
      chk1(index_mark, 1'h0, "no index");
      clk_en <= 1'h0;
      shift_in(5'h15, 5);
      clk_en <= 1'h1;
      chk1(guardband, 1'h0, "frozen shifter holds");
      shift_in(5'h06, 4);
      chk1(index_mark, 1'h1, "index, fifth stage one");
      shift_in(5'h06, 4);
      chk1(index_mark, 1'h1, "index, fifth stage zero");
      $display("test pattern decode done");
      apb(1'h1, CTRL_OFS, 32'h2);
      repeat (3) @(posedge clock);
      chk32(hp_cnt, 32'h1, "single homing pulse");
      chk1(illegal, 1'h0, "restore clears illegal");
      chk1(drive.homing, 1'h1, "homing slew");
      chk1(drive.reverse, 1'h1, "slew toward edge");
      apb(1'h0, STATUS_OFS, 32'h0);
      chk1(rd[6], 1'h1, "inhibit set");
      shift_in(5'h0a, 5);
      chk1(drive.forward, 1'h1, "slew out of guardband");
      for (int i = 0; i < 4000 && rd[6] !== 1'h0; i++) apb(1'h0, STATUS_OFS, 32'h0);
      apb(1'h0, POSITION_OFS, 32'h0);
      chk32(rd, 32'h0100, "parked at 256, demand zeroed");
      wait_done(8000);
      apb(1'h0, POSITION_OFS, 32'h0);
      chk32(rd, 32'h0, "home at zero");
      chk1(ready, 1'h1, "ready after restore");
      $display("test restore done");
      seek(10'h064);
      chk32(ack_cnt, 32'h1, "legal strobe acked");
      chk1(drive.velocity_mode, 1'h1, "velocity mode");
      chk1(drive.forward, 1'h1, "forward");
      chk1(drive.vel_negative, 1'h0, "positive sign");
      chk32(drive.velocity_code, 8'hff, "full speed far out");
      seek(10'h007);
      chk32(ack_cnt, 32'h1, "busy strobe ignored");
      wait_done(6000);
      apb(1'h0, POSITION_OFS, 32'h0);
      chk32(rd, 32'h00640064, "stopped at 100");
      chk1(drive.velocity_mode, 1'h0, "detent");
      chk1(drive.detent_odd, 1'h0, "even slope");
      xing_base = xing_cnt;
      seek(10'h028);
      apb(1'h0, PROFILE_OFS, 32'h0);
      chk32(rd[25:16], 32'h3c, "tracks to go");
      chk1(drive.velocity_code != 8'hff, 1'h1, "profile table");
      chk1(drive.reverse, 1'h1, "reverse");
      chk1(drive.vel_negative, 1'h1, "negative sign");
      wait_done(4000);
      apb(1'h0, POSITION_OFS, 32'h0);
      chk32(rd, 32'h00280028, "stopped at 40");
      chk32(xing_cnt - xing_base, 32'h3c, "merged crossings counted");
      seek(10'h029);
      wait_done(4000);
      chk1(drive.detent_odd, 1'h1, "odd slope");
      $display("test seeks done");
      stall <= 1'h1;
      seek(10'h02c);
      for (int i = 0; i < 6000 && tmo_n !== 1'h0; i++) @(posedge clock);
      chk1(tmo_n, 1'h0, "settle timeout");
      repeat (2) @(posedge clock);
      chk1(drive.positioner_enable, 1'h0, "positioner off");
      chk1(done, 1'h0, "no done on timeout");
      $display("test timeout done");
      test_done();
   end
endmodule : testbench
`default_nettype wire

// ===== rtl/head_seek_restore_logic.sv
// head positioner seek, restore and velocity profile control with apb registers
`timescale 1ns/100ps
`default_nettype none
module head_seek_restore_logic (
   input wire logic clock,
   input wire logic reset,
   input wire logic clk_en,
   input wire seek_pkg::apb_req_s apb_req,
   output seek_pkg::apb_rsp_s apb_rsp,
   input wire seek_pkg::servo_in_s servo,
   output seek_pkg::drive_out_s drive,
   output logic index_mark,
   output logic guardband,
   output logic crossing_pulse_n,
   output logic seek_ack,
   output logic homing_pulse,
   output logic positioning_done,
   output logic illegal_address,
   output logic positioning_timeout_n,
   output logic ready
);
   import seek_pkg::*;

   typedef struct packed {
      logic [PIN_W-1:0] pin_m;
      logic [PIN_W-1:0] pin_s;
      logic [PIN_W-1:0] pin_d;
      seek_e mode;
      logic [CYL_W-1:0] cur;
      logic [CYL_W-1:0] dem;
      logic [CYL_W-1:0] target;
      logic [CYL_W-1:0] limit;
      logic illegal;
      logic done;
      logic ready;
      logic inhibit_n;
      logic timeout;
      logic ack;
      logic home_p;
      logic cross_n;
      logic [TMR_W-1:0] settle_cnt;
      logic [TMR_W-1:0] watch_cnt;
      drive_out_s drive;
      logic [31:0] prdata;
      logic pslverr;
   } state_s;

   state_s s_ff;
   state_s nxt_s;
   logic [CYL_W-1:0] eff_dem;
   logic [CYL_W-1:0] ttg;
   logic slot_rise;
   logic cross_fall;
   logic pos_fall;
   logic wr;
   logic setup;
   logic strobe;
   logic legal;
   logic clear_cylinders_n;
   logic rd_err;
   logic [31:0] rdata;

   function automatic logic [CYL_W-1:0] abs_diff(input logic [CYL_W-1:0] a,
                                                 input logic [CYL_W-1:0] b);
      abs_diff = (a > b) ? a - b : b - a;
   endfunction : abs_diff

   // bitwise integer square root; the profile gives constant deceleration
   function automatic logic [7:0] isqrt16(input logic [15:0] v);
      logic [7:0] r;
      logic [7:0] t;
      logic [15:0] sq;
      r = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         t = r | 8'(1 << i);
         sq = {8'h00, t} * {8'h00, t};
         if (sq <= v) begin
            r = t;
         end
      end
      isqrt16 = r;
   endfunction : isqrt16

   sync_pattern_decoder u_pattern (
      .clock(clock),
      .reset(reset),
      .clk_en(clk_en),
      .shift_en(slot_rise),
      .bit_in(s_ff.pin_s[PIN_SYNC]),
      .index_mark(index_mark),
      .guardband(guardband)
   );

   always_comb begin
      eff_dem = s_ff.dem;
      if (!s_ff.inhibit_n) begin
         eff_dem[HOME_BIT] = 1'b1;
      end
   end

   assign ttg = abs_diff(eff_dem, s_ff.cur);
   // sampled at slot seven, absent sync reads low
   assign slot_rise = s_ff.pin_s[PIN_SLOT] & ~s_ff.pin_d[PIN_SLOT];
   assign cross_fall = (s_ff.pin_d[PIN_POS] & s_ff.pin_d[PIN_NEG])
                       & ~(s_ff.pin_s[PIN_POS] & s_ff.pin_s[PIN_NEG]);
   assign pos_fall = s_ff.pin_d[PIN_POS] & ~s_ff.pin_s[PIN_POS];
   assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign setup = apb_req.psel & ~apb_req.penable;
   assign strobe = wr && apb_req.paddr == CTRL_OFS && apb_req.pwdata[CTRL_SEEK_BIT];
   assign legal = s_ff.target <= s_ff.limit;

   always_comb begin
      rd_err = 1'b0;
      rdata = 32'h0;
      if (apb_req.paddr == CTRL_OFS) begin
         rdata = 32'h0;
      end else if (apb_req.paddr == TARGET_OFS) begin
         rdata = 32'(s_ff.target);
      end else if (apb_req.paddr == LIMIT_OFS) begin
         rdata = 32'(s_ff.limit);
      end else if (apb_req.paddr == STATUS_OFS) begin
         rdata = {22'h0, s_ff.mode, ~s_ff.inhibit_n, guardband, index_mark,
                  s_ff.done, s_ff.illegal, s_ff.timeout, s_ff.ready};
      end else if (apb_req.paddr == POSITION_OFS) begin
         rdata = {6'h00, s_ff.dem, 6'h00, s_ff.cur};
      end else if (apb_req.paddr == PROFILE_OFS) begin
         rdata = {6'h00, ttg, 8'h00, s_ff.drive.velocity_code};
      end else begin
         rd_err = 1'b1;
      end
   end

   always_comb begin
      nxt_s = s_ff;
      nxt_s.pin_m = servo;
      nxt_s.pin_s = s_ff.pin_m;
      nxt_s.pin_d = s_ff.pin_s;
      nxt_s.ack = 1'b0;
      nxt_s.home_p = 1'b0;
      nxt_s.cross_n = s_ff.pin_s[PIN_POS] & s_ff.pin_s[PIN_NEG];
      clear_cylinders_n = 1'b1;
      if (setup) begin
         nxt_s.prdata = apb_req.pwrite ? 32'h0 : rdata;
         nxt_s.pslverr = rd_err;
      end
      if (wr) begin
         if (apb_req.paddr == TARGET_OFS) begin
            nxt_s.target = apb_req.pwdata[CYL_W-1:0];
         end else if (apb_req.paddr == LIMIT_OFS) begin
            nxt_s.limit = apb_req.pwdata[CYL_W-1:0];
         end else if (apb_req.paddr == CTRL_OFS) begin
            nxt_s.home_p = apb_req.pwdata[CTRL_RESTORE_BIT];
         end
      end
      case (s_ff.mode)
         st_detent: begin
            nxt_s.watch_cnt = '0;
         end
         st_velocity: begin
            if (ttg == '0) begin
               nxt_s.mode = st_settle;
               nxt_s.settle_cnt = '0;
               nxt_s.watch_cnt = '0;
            end else if (cross_fall) begin
               nxt_s.cur = (eff_dem > s_ff.cur) ? s_ff.cur + 1'b1 : s_ff.cur - 1'b1;
            end
         end
         st_settle: begin
            nxt_s.watch_cnt = s_ff.watch_cnt + 1'b1;
            if (s_ff.watch_cnt == TIMEOUT_LAST) begin
               nxt_s.timeout = 1'b1;
               nxt_s.mode = st_fault;
            end else if (!s_ff.pin_s[PIN_TRACK]) begin
               nxt_s.settle_cnt = '0;
            end else if (s_ff.settle_cnt == SETTLE_LAST) begin
               if (!s_ff.inhibit_n) begin
                  // release inhibit, seek on to zero
                  nxt_s.inhibit_n = 1'b1;
                  nxt_s.mode = st_velocity;
               end else begin
                  nxt_s.done = 1'b1;
                  nxt_s.ready = 1'b1;
                  nxt_s.mode = st_detent;
               end
            end else begin
               nxt_s.settle_cnt = s_ff.settle_cnt + 1'b1;
            end
         end
         st_slew_in: begin
            if (guardband) begin
               nxt_s.mode = st_slew_out;
            end
         end
         st_slew_out: begin
            if (pos_fall) begin
               clear_cylinders_n = 1'b0;
               nxt_s.cur = '0;
               nxt_s.dem = '0;
               nxt_s.mode = st_velocity;
            end
         end
         st_fault: begin
            nxt_s.watch_cnt = '0;
         end
         default: begin
            nxt_s.mode = st_detent;
         end
      endcase
      if (s_ff.home_p) begin
         nxt_s.mode = st_slew_in;
         nxt_s.inhibit_n = 1'b0;
         nxt_s.illegal = 1'b0;
         if (s_ff.mode != st_settle || s_ff.watch_cnt != TIMEOUT_LAST) begin
            nxt_s.timeout = 1'b0;
         end
         nxt_s.done = 1'b0;
         nxt_s.ready = 1'b0;
      end
      if (strobe) begin
         if (!legal) begin
            // sticky, wins over a restore clear
            nxt_s.illegal = 1'b1;
         end else if (s_ff.done && !s_ff.home_p) begin
            nxt_s.dem = s_ff.target;
            nxt_s.ack = 1'b1;
            nxt_s.done = 1'b0;
            nxt_s.settle_cnt = '0;
            nxt_s.watch_cnt = '0;
            // leave detent when the cylinder changes
            nxt_s.mode = (s_ff.target != s_ff.cur) ? st_velocity : st_settle;
         end
      end
      nxt_s.drive = '0;
      nxt_s.drive.positioner_enable = ~s_ff.timeout;
      nxt_s.drive.detent_odd = eff_dem[0];
      if (s_ff.mode == st_velocity) begin
         nxt_s.drive.velocity_mode = 1'b1;
         nxt_s.drive.forward = eff_dem > s_ff.cur;
         nxt_s.drive.reverse = s_ff.cur > eff_dem;
         nxt_s.drive.velocity_code = (ttg > PROFILE_SPAN) ? 8'hff
            : isqrt16(16'(ttg[6:0]) * PROFILE_SCALE);
      end else if (s_ff.mode == st_slew_in || s_ff.mode == st_slew_out) begin
         nxt_s.drive.velocity_mode = 1'b1;
         nxt_s.drive.homing = 1'b1;
         nxt_s.drive.forward = s_ff.mode == st_slew_out;
         nxt_s.drive.reverse = s_ff.mode == st_slew_in;
         nxt_s.drive.velocity_code = SLEW_CODE;
      end
      nxt_s.drive.vel_negative = nxt_s.drive.reverse;
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         s_ff <= '{mode: st_detent, limit: LIMIT_RESET, inhibit_n: 1'b1,
                   pin_m: '1, pin_s: '1, pin_d: '1, cross_n: 1'b1, default: '0};
      end else if (clk_en) begin
         s_ff <= nxt_s;
      end
   end

   // pready follows the enable so a frozen block never completes a transfer
   assign apb_rsp = '{prdata: s_ff.prdata, pready: clk_en, pslverr: s_ff.pslverr};
   assign drive = s_ff.drive;
   assign crossing_pulse_n = s_ff.cross_n;
   assign seek_ack = s_ff.ack;
   assign homing_pulse = s_ff.home_p;
   assign positioning_done = s_ff.done;
   assign illegal_address = s_ff.illegal;
   assign positioning_timeout_n = ~s_ff.timeout;
   assign ready = s_ff.ready;

   default clocking @(posedge clock); endclocking
   default disable iff (reset);

   crossing_merge_a: assert property (clk_en ##1 clk_en |->
      crossing_pulse_n == ($past(s_ff.pin_s[PIN_POS]) & $past(s_ff.pin_s[PIN_NEG])))
      else $error("crossing merge wrong");
   illegal_block_a: assert property (clk_en && strobe && !legal |=>
      !seek_ack && illegal_address) else $error("illegal address latched");
   busy_ignore_a: assert property (clk_en && strobe && !s_ff.done
      && s_ff.mode != st_slew_out |=> !seek_ack && s_ff.dem == $past(s_ff.dem))
      else $error("strobe taken while busy");
   ack_latch_a: assert property (clk_en && strobe && legal && s_ff.done && !s_ff.home_p |=>
      seek_ack && s_ff.dem == $past(s_ff.target) && !positioning_done)
      else $error("legal strobe not latched");
   illegal_sticky_a: assert property (clk_en && illegal_address && !homing_pulse |=>
      illegal_address) else $error("illegal status lost");
   velocity_leave_a: assert property (clk_en && strobe && legal && s_ff.done && !s_ff.home_p
      && s_ff.target != s_ff.cur |=> s_ff.mode == st_velocity) else $error("detent not left");
   forward_count_a: assert property (clk_en && s_ff.mode == st_velocity && ttg != '0
      && cross_fall && eff_dem > s_ff.cur |=> s_ff.cur == $past(s_ff.cur) + 1'b1)
      else $error("forward count wrong");
   reverse_count_a: assert property (clk_en && s_ff.mode == st_velocity && ttg != '0
      && cross_fall && s_ff.cur > eff_dem |=> s_ff.cur == $past(s_ff.cur) - 1'b1)
      else $error("reverse count wrong");
   detent_enter_a: assert property (clk_en && s_ff.mode == st_velocity && ttg == '0
      && !homing_pulse |=> s_ff.mode == st_settle && s_ff.cur == $past(s_ff.cur))
      else $error("detent not entered");
   settle_done_a: assert property (clk_en && s_ff.mode == st_settle && s_ff.inhibit_n
      && s_ff.pin_s[PIN_TRACK] && s_ff.settle_cnt == SETTLE_LAST && s_ff.watch_cnt != TIMEOUT_LAST
      && !homing_pulse |=> positioning_done && ready) else $error("done not set");
   homing_start_a: assert property (clk_en && homing_pulse |=>
      s_ff.mode == st_slew_in && !s_ff.inhibit_n && !ready) else $error("restore ignored");
   store_zero_a: assert property (clk_en && s_ff.mode == st_slew_out && pos_fall |=>
      s_ff.cur == '0 && s_ff.dem == '0) else $error("store zero missed");
   inhibit_release_a: assert property (clk_en && s_ff.mode == st_settle && !s_ff.inhibit_n
      && s_ff.pin_s[PIN_TRACK] && s_ff.settle_cnt == SETTLE_LAST && s_ff.watch_cnt != TIMEOUT_LAST
      && !homing_pulse |=> s_ff.inhibit_n && s_ff.mode == st_velocity) else $error("no release");
   profile_high_a: assert property ($past(clk_en && s_ff.mode == st_velocity
      && ttg > PROFILE_SPAN) |-> drive.velocity_code == 8'hff) else $error("profile low");
   timeout_disable_a: assert property (clk_en && !positioning_timeout_n |=>
      !drive.positioner_enable) else $error("positioner still enabled");

   seek_done_c: cover property ($rose(positioning_done));
   restore_done_c: cover property ($rose(ready));
   illegal_set_c: cover property ($rose(illegal_address));
   timeout_c: cover property ($fell(positioning_timeout_n));
endmodule : head_seek_restore_logic
`default_nettype wire

// ===== rtl/seek_pkg.sv
// shared constants and carrier types for the head seek and restore logic
package seek_pkg;
   localparam int CYL_W = 10;
   localparam int TMR_W = 12;
   localparam int CLOCK_NS = 20;
   // on-track delay is a least time, the timeout a longest time
   localparam int SETTLE_TIME_NS = 40000;
   localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLOCK_NS - 1) / CLOCK_NS;
   localparam int TIMEOUT_TIME_NS = 80000;
   localparam int TIMEOUT_CYCLES = TIMEOUT_TIME_NS / CLOCK_NS;
   localparam logic [TMR_W-1:0] SETTLE_LAST = TMR_W'(SETTLE_CYCLES - 1);
   localparam logic [TMR_W-1:0] TIMEOUT_LAST = TMR_W'(TIMEOUT_CYCLES - 1);
   localparam int HOME_BIT = 8;
   localparam logic [CYL_W-1:0] PROFILE_SPAN = 10'h040;
   localparam logic [15:0] PROFILE_SCALE = 16'h03fc;
   localparam logic [7:0] SLEW_CODE = 8'h10;
   localparam logic [CYL_W-1:0] LIMIT_RESET = 10'h31f;
   localparam logic [3:0] INDEX_PAT = 4'h6;
   localparam logic [4:0] GUARD_PAT_A = 5'h0a;
   localparam logic [4:0] GUARD_PAT_B = 5'h15;
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] TARGET_OFS = 12'h004;
   localparam logic [11:0] LIMIT_OFS = 12'h008;
   localparam logic [11:0] STATUS_OFS = 12'h00c;
   localparam logic [11:0] POSITION_OFS = 12'h010;
   localparam logic [11:0] PROFILE_OFS = 12'h014;
   localparam int CTRL_SEEK_BIT = 0;
   localparam int CTRL_RESTORE_BIT = 1;
   // bit positions inside servo_in_s
   localparam int PIN_W = 5;
   localparam int PIN_POS = 4;
   localparam int PIN_NEG = 3;
   localparam int PIN_TRACK = 2;
   localparam int PIN_SYNC = 1;
   localparam int PIN_SLOT = 0;

   typedef enum logic [2:0] {
      st_detent, st_velocity, st_settle, st_slew_in, st_slew_out, st_fault
   } seek_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_s;

   typedef struct packed {
      logic pos_crossing_pulse_n;
      logic neg_crossing_pulse_n;
      logic on_track;
      logic sync_presence_bit;
      logic slot_seven;
   } servo_in_s;

   typedef struct packed {
      logic velocity_mode;
      logic forward;
      logic reverse;
      logic vel_negative;
      logic detent_odd;
      logic homing;
      logic positioner_enable;
      logic [7:0] velocity_code;
   } drive_out_s;
endpackage : seek_pkg

// ===== rtl/sync_pattern_decoder.sv
// five-stage sync presence shifter with index and guardband decode
`timescale 1ns/100ps
`default_nettype none
module sync_pattern_decoder (
   input wire logic clock,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic shift_en,
   input wire logic bit_in,
   output logic index_mark,
   output logic guardband
);
   import seek_pkg::*;

   typedef struct packed {
      logic [4:0] stages;
      logic index_mark;
      logic guardband;
   } pattern_s;

   pattern_s s_ff;
   pattern_s nxt_s;

   always_comb begin
      nxt_s = s_ff;
      if (shift_en) begin
         nxt_s.stages = {s_ff.stages[3:0], bit_in};
      end
      nxt_s.index_mark = (s_ff.stages[3:0] == INDEX_PAT);
      nxt_s.guardband = (s_ff.stages == GUARD_PAT_A) || (s_ff.stages == GUARD_PAT_B);
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         s_ff <= '0;
      end else if (clk_en) begin
         s_ff <= nxt_s;
      end
   end

   assign index_mark = s_ff.index_mark;
   assign guardband = s_ff.guardband;

   default clocking @(posedge clock); endclocking
   default disable iff (reset);

   shift_order_a: assert property (clk_en && shift_en |=>
      s_ff.stages == {$past(s_ff.stages[3:0]), $past(bit_in)}) else $error("stage shift wrong");
   index_decode_a: assert property (clk_en && s_ff.stages[3:0] == INDEX_PAT |=> index_mark)
      else $error("index missed");
   guard_decode_a: assert property (clk_en && s_ff.stages != GUARD_PAT_A
      && s_ff.stages != GUARD_PAT_B |=> !guardband) else $error("guardband false");
endmodule : sync_pattern_decoder
`default_nettype wire
